// ===== design/ddrmr_pkg.sv
// Package for the command front end and mode register block
package ddrmr_pkg;
   // ==========================================================
   // Widths
   // ==========================================================
   localparam int ADDR_W = 13;   // Address lines
   localparam int BANK_W = 3;    // Bank pick lines
   localparam int NBANK = 8;     // Bank count
   localparam int COL_W = 10;    // Column width
   localparam int AP_BIT = 10;   // Auto-precharge flag position
   // ==========================================================
   // Mode word field positions
   // ==========================================================
   localparam int MR_BL_LO = 0;
   localparam int MR_BL_HI = 2;
   localparam int MR_BT_BIT = 3;
   localparam int MR_CL_LO = 4;
   localparam int MR_CL_HI = 6;
   localparam int MR_TM_BIT = 7;
   localparam int MR_DLLRST_BIT = 8;
   localparam int MR_WR_LO = 9;
   localparam int MR_WR_HI = 11;
   // Burst length codes, earlier generation encoding
   localparam logic [2:0] BL_CODE_4 = 3'h2;
   localparam logic [2:0] BL_CODE_8 = 3'h3;
   localparam logic [3:0] BL_4 = 4'h4;
   localparam logic [3:0] BL_8 = 4'h8;
   // ==========================================================
   // Extended register 1 and 2 field positions
   // ==========================================================
   localparam int E1_DLL_BIT = 0;
   localparam int E1_DRV_BIT = 1;
   localparam int E1_RTT0_BIT = 2;
   localparam int E1_AL_LO = 3;
   localparam int E1_AL_HI = 5;
   localparam int E1_RTT1_BIT = 6;
   localparam int E1_CAL_LO = 7;
   localparam int E1_CAL_HI = 9;
   localparam int E1_NDQS_BIT = 10;
   localparam int E2_SRT_BIT = 7;
   // Calibration field codes
   localparam logic [2:0] CAL_EXIT = 3'h0;
   localparam logic [2:0] CAL_DRV1 = 3'h1;
   localparam logic [2:0] CAL_DRV0 = 3'h2;
   localparam logic [2:0] CAL_ADJ = 3'h4;
   localparam logic [2:0] CAL_DFLT = 3'h7;
   // Register selection by bank pick
   localparam logic [2:0] SEL_MR = 3'h0;
   localparam logic [2:0] SEL_E1 = 3'h1;
   localparam logic [2:0] SEL_E2 = 3'h2;
   localparam logic [2:0] SEL_E3 = 3'h3;
   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 10;
   localparam int MODE_SET_CYCLES = 2;      // Link clocks to complete a mode write
   localparam int DLL_LOCK_CYCLES = 200;    // Link clocks after loop reset
   // ==========================================================
   // Command codes {cs_n, ras_n, cas_n, we_n}
   // ==========================================================
   typedef enum logic [3:0] {
      CMD_MRS = 4'h0, CMD_REF = 4'h1, CMD_PRE = 4'h2, CMD_ACT = 4'h3,
      CMD_WR = 4'h4, CMD_RD = 4'h5, CMD_BST = 4'h6, CMD_NOP = 4'h7
   } ddrmr_cmd_t;
   // Sampled command bundle
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [BANK_W-1:0] bank_pick;
      logic [ADDR_W-1:0] addr;
   } ddrmr_cmdbus_t;
   // Decoded mode fields
   typedef struct packed {
      logic [3:0] burst_len;
      logic burst_interleave;
      logic [2:0] column_latency;
      logic test_mode;
      logic [2:0] write_recovery;
      logic [2:0] posted_delay;
      logic reduced_drive;
      logic [1:0] term_sel;
      logic [2:0] cal_mode;
      logic diff_strobe;
      logic ext_self_refresh;
   } ddrmr_mode_t;
endpackage : ddrmr_pkg

// ===== design/ddrmr_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module ddrmr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // First stage feeds only the second stage
   logic [WIDTH-1:0] meta_q;
   // Both stages freeze with the clock enable
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         meta_q <= '0;
         sync_out <= '0;
      end
      else if (clk_en_in)
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : ddrmr_sync

// ===== design/ddrmr_modereg.sv
// Storage of the mode word and the three extended words
`timescale 1ns/10ps
module ddrmr_modereg
   import ddrmr_pkg::*;
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic wr_in,
   input wire logic [BANK_W-1:0] sel_in,
   input wire logic [ADDR_W-1:0] data_in,
   output logic [ADDR_W-1:0] mode_word_out,
   output logic [ADDR_W-1:0] ext1_out,
   output logic [ADDR_W-1:0] ext2_out,
   output logic [ADDR_W-1:0] ext3_out
);
   // ==========================================================
   // One register per selectable word
   // ==========================================================
   logic [3:0][ADDR_W-1:0] word_q;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_word
         // Undefined at power-up; cleared so simulation stays known
         always_ff @(posedge mclk_in)
         begin
            if (sys_rst_in)
               word_q[gi] <= '0;
            else if (clk_en_in && wr_in && sel_in == BANK_W'(gi))
               word_q[gi] <= data_in;
         end
      end
   endgenerate
   assign mode_word_out = word_q[SEL_MR];
   assign ext1_out = word_q[SEL_E1];
   assign ext2_out = word_q[SEL_E2];
   assign ext3_out = word_q[SEL_E3];
endmodule : ddrmr_modereg

// ===== design/ddrmr_core.sv
// Command front end, bank state and mode programming of the memory device
`timescale 1ns/10ps
// Contract
// - Chip select high means deselect
// - Decode strobes at rising link clock
// - Row full address; column low ten, A10 precharge
// - Bank pick selects target bank
// - Masked write beats are discarded
// - Lower strobe low byte, upper high
// - Complementary strobes only in differential mode
// - Termination on while enable registered high
// - Clock enable gates internal clocking
// - Mode write needs idle banks, enable high
// - Burst length from A2..A0, four/eight
// - Burst type A3, latency A6..A4
// - A7 test mode, A8 loop reset
// - Extended 1 field layout
// - Calibration field codes
module ddrmr_core
   import ddrmr_pkg::*;
#(
   parameter int DLL_LOCK = DLL_LOCK_CYCLES
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic link_clk_in,
   input wire logic mem_cke_in,
   input wire logic termination_enable_in,
   input wire logic cs_n_in,
   input wire logic ras_n_in,
   input wire logic cas_n_in,
   input wire logic we_n_in,
   input wire logic [BANK_W-1:0] bank_pick_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic lower_byte_mask_in,
   input wire logic upper_byte_mask_in,
   input wire logic [15:0] data_lines_in,
   output logic cmd_valid_out,
   output logic [3:0] cmd_code_out,
   output logic [BANK_W-1:0] cmd_bank_out,
   output logic [ADDR_W-1:0] row_out,
   output logic [COL_W-1:0] col_out,
   output logic auto_pre_out,
   output logic [NBANK-1:0] bank_open_out,
   output logic [15:0] write_data_out,
   output logic [1:0] write_byte_en_out,
   output logic clocking_on_out,
   output logic term_on_out,
   output logic diff_strobe_out,
   output logic mode_busy_out,
   output logic dll_locked_out,
   output logic illegal_mode_out,
   output ddrmr_mode_t mode_out
);
   // ==========================================================
   // Pin synchronisation
   // ==========================================================
   localparam int SW = 2 + 4 + BANK_W + ADDR_W + 2 + 16 + 1;
   logic [SW-1:0] pins_s;
   ddrmr_cmdbus_t cb_s;           // Synchronised command bundle
   logic cke_s, odt_s, lclk_s, ldm_s, udm_s;
   logic [15:0] dq_s;
   ddrmr_sync #(.WIDTH(SW)) u_sync (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .clk_en_in(clk_en_in),
      .async_in({mem_cke_in, termination_enable_in, cs_n_in, ras_n_in, cas_n_in,
                 we_n_in, bank_pick_in, addr_in, lower_byte_mask_in,
                 upper_byte_mask_in, data_lines_in, link_clk_in}),
      .sync_out(pins_s)
   );
   assign {cke_s, odt_s, cb_s, ldm_s, udm_s, dq_s, lclk_s} = pins_s;
   // ==========================================================
   // Link clock edge detection (only synchronised copy is read)
   // ==========================================================
   logic lclk_q;
   logic rise, fall;
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         lclk_q <= 1'b0;
      else if (clk_en_in)
         lclk_q <= lclk_s;
   end
   assign rise = clk_en_in && lclk_s && !lclk_q;
   assign fall = clk_en_in && !lclk_s && lclk_q;
   // ==========================================================
   // Clock enable and termination, registered at link edge
   // ==========================================================
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         clocking_on_out <= 1'b0;
         term_on_out <= 1'b0;
      end
      else if (rise)
      begin
         clocking_on_out <= cke_s;
         term_on_out <= odt_s;
      end
   end
   // ==========================================================
   // Command decode
   // ==========================================================
   logic [3:0] code;
   logic live;
   // Deselect masks every command; decoding needs clocking active
   assign code = {cb_s.cs_n, cb_s.ras_n, cb_s.cas_n, cb_s.we_n};
   assign live = rise && clocking_on_out && !cb_s.cs_n;
   logic is_mrs, is_act, is_pre, is_rd, is_wr;
   logic all_idle;
   assign is_mrs = live && code == CMD_MRS;
   assign is_act = live && code == CMD_ACT;
   assign is_pre = live && code == CMD_PRE;
   assign is_rd = live && code == CMD_RD;
   assign is_wr = live && code == CMD_WR;
   assign all_idle = bank_open_out == '0;
   // Registered command report for the array side
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         cmd_valid_out <= 1'b0;
         cmd_code_out <= CMD_NOP;
         cmd_bank_out <= '0;
         row_out <= '0;
         col_out <= '0;
         auto_pre_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         cmd_valid_out <= live && code != CMD_NOP;
         if (live)
         begin
            cmd_code_out <= code;
            cmd_bank_out <= cb_s.bank_pick;
            if (is_act)
               row_out <= cb_s.addr;
            if (is_rd || is_wr)
            begin
               col_out <= cb_s.addr[COL_W-1:0];
               auto_pre_out <= cb_s.addr[AP_BIT];
            end
         end
      end
   end
   // ==========================================================
   // Bank open state, one flag per bank
   // ==========================================================
   genvar gb;
   generate
      for (gb = 0; gb < NBANK; gb++)
      begin : g_bank
         always_ff @(posedge mclk_in)
         begin
            if (sys_rst_in)
               bank_open_out[gb] <= 1'b0;
            else if (is_act && cb_s.bank_pick == BANK_W'(gb))
               bank_open_out[gb] <= 1'b1;
            else if (is_pre && (cb_s.addr[AP_BIT] || cb_s.bank_pick == BANK_W'(gb)))
               bank_open_out[gb] <= 1'b0;
            else if ((is_rd || is_wr) && cb_s.addr[AP_BIT] &&
                     cb_s.bank_pick == BANK_W'(gb))
               bank_open_out[gb] <= 1'b0;
         end
      end
   endgenerate
   // ==========================================================
   // Mode write acceptance and completion timer
   // ==========================================================
   logic mode_wr;
   logic [2:0] mset_q;
   // Writes while busy or with banks open are dropped, not queued
   assign mode_wr = is_mrs && all_idle && cke_s && mset_q == '0;
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         mset_q <= '0;
      else if (mode_wr)
         mset_q <= 3'(MODE_SET_CYCLES);
      else if (rise && mset_q != '0)
         mset_q <= mset_q - 3'h1;
   end
   assign mode_busy_out = mset_q != '0;
   logic [ADDR_W-1:0] mr_w, e1_w, e2_w, e3_w;
   ddrmr_modereg u_regs (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .clk_en_in(clk_en_in),
      .wr_in(mode_wr),
      .sel_in(cb_s.bank_pick),
      .data_in(cb_s.addr),
      .mode_word_out(mr_w),
      .ext1_out(e1_w),
      .ext2_out(e2_w),
      .ext3_out(e3_w)
   );
   // ==========================================================
   // Field decode of the stored words
   // ==========================================================
   logic [2:0] bl_code;
   always_comb
   begin
      bl_code = mr_w[MR_BL_HI:MR_BL_LO];
      mode_out.burst_len = (bl_code == BL_CODE_8) ? BL_8 : BL_4;
      mode_out.burst_interleave = mr_w[MR_BT_BIT];
      mode_out.column_latency = mr_w[MR_CL_HI:MR_CL_LO];
      mode_out.test_mode = mr_w[MR_TM_BIT];
      mode_out.write_recovery = mr_w[MR_WR_HI:MR_WR_LO];
      mode_out.posted_delay = e1_w[E1_AL_HI:E1_AL_LO];
      mode_out.reduced_drive = e1_w[E1_DRV_BIT];
      mode_out.term_sel = {e1_w[E1_RTT1_BIT], e1_w[E1_RTT0_BIT]};
      mode_out.cal_mode = e1_w[E1_CAL_HI:E1_CAL_LO];
      mode_out.diff_strobe = !e1_w[E1_NDQS_BIT];
      mode_out.ext_self_refresh = e2_w[E2_SRT_BIT];
   end
   // Only four and eight are legal; half-clock latencies absent
   logic cal_bad;
   assign cal_bad = !(mode_out.cal_mode inside {CAL_EXIT, CAL_DRV1, CAL_DRV0, CAL_ADJ,
                                                CAL_DFLT});
   assign illegal_mode_out = !(bl_code inside {BL_CODE_4, BL_CODE_8}) ||
                             mode_out.test_mode || cal_bad;
   assign diff_strobe_out = mode_out.diff_strobe;
   // ==========================================================
   // Loop lock counter, restarted by a loop reset write
   // ==========================================================
   logic [8:0] lock_q;
   logic dll_rst_wr;
   assign dll_rst_wr = mode_wr && cb_s.bank_pick == SEL_MR && cb_s.addr[MR_DLLRST_BIT];
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         lock_q <= '0;
      else if (dll_rst_wr)
         lock_q <= 9'(DLL_LOCK);
      else if (rise && lock_q != '0)
         lock_q <= lock_q - 9'h1;
   end
   assign dll_locked_out = e1_w[E1_DLL_BIT] == 1'b0 && lock_q == '0 && clocking_on_out;
   // ==========================================================
   // Write data capture on both link edges with byte masks
   // ==========================================================
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         write_data_out <= '0;
         write_byte_en_out <= '0;
      end
      else if (rise || fall)
      begin
         // Lower mask guards bits 7..0, upper bits 15..8
         write_byte_en_out <= {!udm_s, !ldm_s};
         if (!ldm_s)
            write_data_out[7:0] <= dq_s[7:0];
         if (!udm_s)
            write_data_out[15:8] <= dq_s[15:8];
      end
      else if (clk_en_in)
         write_byte_en_out <= '0;
   end
   // ==========================================================
   // Checks
   // ==========================================================
   property p_deselect;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (rise && cb_s.cs_n) |=> !cmd_valid_out;
   endproperty
   a_deselect: assert property (p_deselect) else $error("deselect cycle decoded");
   property p_row;
      @(posedge mclk_in) disable iff (sys_rst_in)
      is_act |=> row_out == $past(cb_s.addr) && cmd_code_out == CMD_ACT;
   endproperty
   a_row: assert property (p_row) else $error("row not captured");
   property p_bank;
      @(posedge mclk_in) disable iff (sys_rst_in)
      is_act |=> bank_open_out[$past(cb_s.bank_pick)];
   endproperty
   a_bank: assert property (p_bank) else $error("bank not opened");
   property p_mask;
      @(posedge mclk_in) disable iff (sys_rst_in)
      ((rise || fall) && ldm_s) |=> $stable(write_data_out[7:0]) && !write_byte_en_out[0];
   endproperty
   a_mask: assert property (p_mask) else $error("masked beat stored");
   property p_term;
      @(posedge mclk_in) disable iff (sys_rst_in)
      rise |=> term_on_out == $past(odt_s);
   endproperty
   a_term: assert property (p_term) else $error("termination not registered");
   property p_cke;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (rise && !cke_s) |=> !clocking_on_out;
   endproperty
   a_cke: assert property (p_cke) else $error("clocking not stopped");
   property p_mrs_guard;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (is_mrs && !all_idle) |=> $stable(mr_w) && $stable(e1_w);
   endproperty
   a_mrs_guard: assert property (p_mrs_guard) else $error("mode written with open bank");
   sequence s_mrs_done;
      mode_busy_out ##[1:100] !mode_busy_out;
   endsequence
   property p_mrs_busy;
      @(posedge mclk_in) disable iff (sys_rst_in)
      mode_wr |=> s_mrs_done;
   endproperty
   a_mrs_busy: assert property (p_mrs_busy) else $error("mode set time wrong");
   property p_bl;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (mr_w[MR_BL_HI:MR_BL_LO] == BL_CODE_8) |-> mode_out.burst_len == BL_8;
   endproperty
   a_bl: assert property (p_bl) else $error("burst length decode wrong");
   property p_dqs;
      @(posedge mclk_in) disable iff (sys_rst_in)
      diff_strobe_out != e1_w[E1_NDQS_BIT];
   endproperty
   a_dqs: assert property (p_dqs) else $error("strobe mode wrong");
endmodule : ddrmr_core

// ===== verification/ddrmr_host_model.sv
// Memory controller model: link clock, power-up, init commands and data pins
`timescale 1ns/10ps
module ddrmr_host_model
   import ddrmr_pkg::*;
#(
   parameter int LOCK_CLKS = 200,    // Link clocks waited after loop reset
   parameter int STABLE_CLKS = 1250  // 200 us of link clock at 160 ns
) (
   input wire logic mclk_in,
   output logic link_clk_out,
   output logic cke_out,
   output logic term_out,
   output ddrmr_cmdbus_t cmd_out,
   output logic lmask_out,
   output logic umask_out,
   output logic [15:0] data_out
);
   // ==========================================================
   // Link clock and power-up pin levels
   // ==========================================================
   // Odd offset keeps link edges clear of the system clock edges
   initial
   begin
      link_clk_out = 1'b0;
      cke_out = 1'b0;
      term_out = 1'b0;
      cmd_out = '1;
      {lmask_out, umask_out, data_out} = '0;
      #3.3;
      forever #80 link_clk_out = ~link_clk_out;
   end
   // ==========================================================
   // One command, held a whole link period around its rising edge
   // ==========================================================
   task automatic send_cmd(input logic [3:0] c, input logic [BANK_W-1:0] bk,
      input logic [ADDR_W-1:0] ad, input int idle);
      @(negedge link_clk_out);
      @(posedge mclk_in);
      {cmd_out.cs_n, cmd_out.ras_n, cmd_out.cas_n, cmd_out.we_n} <= c;
      cmd_out.bank_pick <= bk;
      cmd_out.addr <= ad;
      @(negedge link_clk_out);
      @(posedge mclk_in);
      // Deselect; released lines flip so stale values never look valid
      cmd_out.cs_n <= 1'b1;
      cmd_out.bank_pick <= ~bk;
      cmd_out.addr <= ~ad;
      repeat (idle) @(negedge link_clk_out);
   endtask : send_cmd
   // Termination and write data pins
   task automatic set_pins(input logic t, input logic [15:0] d, input logic lm,
      input logic um);
      @(posedge mclk_in);
      term_out <= t;
      data_out <= d;
      lmask_out <= lm;
      umask_out <= um;
   endtask : set_pins
   // ==========================================================
   // Power-up and initialization
   // ==========================================================
   task automatic power_up();
      repeat (STABLE_CLKS) @(negedge link_clk_out);
      @(posedge mclk_in);
      cke_out <= 1'b1;
      repeat (3) @(negedge link_clk_out);
   endtask : power_up
   task automatic init_seq(input logic [ADDR_W-1:0] mr, input logic [ADDR_W-1:0] e1);
      send_cmd(CMD_PRE, 3'h0, 13'h0400, 0);
      send_cmd(CMD_MRS, SEL_E2, 13'h0000, 2);
      send_cmd(CMD_MRS, SEL_E3, 13'h0000, 2);
      send_cmd(CMD_MRS, SEL_E1, e1 & 13'h1C7E, 2);
      send_cmd(CMD_MRS, SEL_MR, 13'h0100, 2);
      send_cmd(CMD_PRE, 3'h0, 13'h0400, 0);
      send_cmd(CMD_REF, 3'h0, 13'h0000, 0);
      send_cmd(CMD_REF, 3'h0, 13'h0000, 0);
      send_cmd(CMD_MRS, SEL_MR, mr & 13'h1E7F, 2);
      repeat (LOCK_CLKS) @(negedge link_clk_out);
      send_cmd(CMD_MRS, SEL_E1, (e1 & 13'h1C7E) | 13'h0380, 2);
      send_cmd(CMD_MRS, SEL_E1, e1 & 13'h1C7E, 2);
   endtask : init_seq
endmodule : ddrmr_host_model

// ===== verification/test_ddrmr_core.sv
// Self-checking bench for the command front end and mode register block
`timescale 1ns/10ps
module test_ddrmr_core;
   import ddrmr_pkg::*;
   // ==========================================================
   // Signals
   // ==========================================================
   logic mclk_in, sys_rst_in, lk, cke, term, lm, um, cvalid, apre, clk_on, t_on;
   logic diff, busy, locked, illegal;
   logic [15:0] dq, wdata, d1, d2;
   ddrmr_cmdbus_t cb;
   ddrmr_mode_t mode;
   logic [3:0] code;
   logic [2:0] cbank, b;
   logic [ADDR_W-1:0] row, mr, e1, a;
   logic [COL_W-1:0] col;
   logic [NBANK-1:0] bopen;
   logic [1:0] be;
   logic en = 1'b1;  // Clock enable, dropped once to check the freeze
   logic [1:0] last_be = 2'b00;
   logic [2:0] blc [3] = '{BL_CODE_4, BL_CODE_8, 3'h5};  // Last one is illegal
   int errors = 0, n_tests = 0, n_cmd = 0;
   integer seed = 32'hb4c9;
   ddrmr_host_model #(.LOCK_CLKS(200)) host (.mclk_in(mclk_in), .link_clk_out(lk),
      .cke_out(cke), .term_out(term), .cmd_out(cb), .lmask_out(lm), .umask_out(um),
      .data_out(dq));
   // Short lock count; the host still waits its full 200 link clocks
   ddrmr_core #(.DLL_LOCK(4)) dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .clk_en_in(en), .link_clk_in(lk), .mem_cke_in(cke), .termination_enable_in(term),
      .cs_n_in(cb.cs_n), .ras_n_in(cb.ras_n), .cas_n_in(cb.cas_n), .we_n_in(cb.we_n),
      .bank_pick_in(cb.bank_pick), .addr_in(cb.addr), .lower_byte_mask_in(lm),
      .upper_byte_mask_in(um), .data_lines_in(dq), .cmd_valid_out(cvalid),
      .cmd_code_out(code), .cmd_bank_out(cbank), .row_out(row), .col_out(col),
      .auto_pre_out(apre), .bank_open_out(bopen), .write_data_out(wdata),
      .write_byte_en_out(be), .clocking_on_out(clk_on), .term_on_out(t_on),
      .diff_strobe_out(diff), .mode_busy_out(busy), .dll_locked_out(locked),
      .illegal_mode_out(illegal), .mode_out(mode));
   // ==========================================================
   // Clock, watchdog and output monitor
   // ==========================================================
   initial
   begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   initial
   begin
      #1000000;
      errors++;
      $display("Error at %0t: timeout got %0h expected %0h", $time, 0, 1);
      stop_test();
   end
   // Counts command pulses and keeps the last non-zero byte enable seen
   always @(posedge mclk_in)
   begin
      if (cvalid === 1'b1)
         n_cmd <= n_cmd + 1;
      if (be !== 2'b00)
         last_be <= be;
   end
   // ==========================================================
   // Checks and expectations
   // ==========================================================
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk_val
   function automatic logic [3:0] exp_bl(input logic [2:0] c);
      return (c == BL_CODE_8) ? BL_8 : BL_4;
   endfunction : exp_bl
   task automatic chk_mode(input logic [ADDR_W-1:0] m);
      chk_val(16'({mode.burst_len, mode.burst_interleave, mode.column_latency,
         mode.test_mode, mode.write_recovery}),
         16'({exp_bl(m[2:0]), m[3], m[6:4], 1'b0, m[11:9]}));
      chk_val(16'(illegal), 16'(m[2:0] != BL_CODE_4 && m[2:0] != BL_CODE_8));
   endtask : chk_mode
   // A command; counts the pulses it caused and checks its code when one pulse is expected
   task automatic do_cmd(input logic [3:0] c, input logic [2:0] bk,
      input logic [ADDR_W-1:0] ad, input int idle, input int exp_n);
      int n0;
      n0 = n_cmd;
      host.send_cmd(c, bk, ad, idle);
      chk_val(16'(n_cmd - n0), 16'(exp_n));
      if (exp_n == 1)
         chk_val(16'(code), 16'(c));
   endtask : do_cmd
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial
   begin
      sys_rst_in = 1'b1;
      repeat (3) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      @(posedge mclk_in);
      #1;
      chk_val(16'({code, mode.burst_len, diff, clk_on}), 16'({4'(CMD_NOP), BL_4, 1'b1, 1'b0}));
      do_cmd(CMD_ACT, 3'h0, 13'h0000, 0, 0);
      $display("Done: reset and clock enable low");
      host.power_up();
      chk_val(16'(clk_on), 16'h1);
      mr = 13'($random(seed)) & 13'h0E78;
      mr[2:0] = ($random(seed) & 1) ? BL_CODE_8 : BL_CODE_4;
      e1 = 13'($random(seed)) & 13'h047E;
      host.init_seq(mr, e1);
      chk_mode(mr);
      chk_val(16'({mode.posted_delay, mode.reduced_drive, mode.term_sel, mode.cal_mode,
         mode.ext_self_refresh}),
         16'({e1[5:3], e1[1], e1[6], e1[2], CAL_EXIT, 1'b0}));
      chk_val(16'({locked, busy, diff, mode.diff_strobe}), 16'({2'b10, ~e1[10], ~e1[10]}));
      $display("Done: initialization");
      b = 3'($random(seed));
      a = 13'($random(seed));
      do_cmd(CMD_ACT, b, a, 0, 1);
      chk_val(16'({cbank, row}), 16'({b, a}));
      chk_val(16'(bopen), 16'(8'(1 << b)));
      host.send_cmd(CMD_MRS, SEL_MR, mr ^ 13'h0008, 2);
      chk_mode(mr);
      a = 13'($random(seed)) | 13'h0400;
      do_cmd(CMD_WR, b, a, 0, 1);
      chk_val(16'({apre, col}), 16'({1'b1, a[9:0]}));
      chk_val(16'(bopen), 16'h0000);
      do_cmd(CMD_ACT, b + 3'h1, a, 0, 1);
      do_cmd(CMD_RD, b + 3'h1, a & 13'h03FF, 0, 1);
      chk_val(16'({apre, cbank, bopen}), 16'({1'b0, b + 3'h1, 8'(1 << (b + 3'h1))}));
      do_cmd(CMD_PRE, 3'h0, 13'h0400, 0, 1);
      do_cmd(4'hB, b, a, 0, 0);
      // Frozen block must ignore an activate entirely
      en <= 1'b0;
      do_cmd(CMD_ACT, b, a, 0, 0);
      en <= 1'b1;
      chk_val(16'(bopen), 16'h0000);
      $display("Done: bank commands");
      foreach (blc[i])
      begin
         mr[2:0] = blc[i];
         do_cmd(CMD_MRS, SEL_MR, mr, 2, 1);
         chk_mode(mr);
      end
      do_cmd(CMD_MRS, SEL_E1, 13'h0400, 2, 1);
      chk_val(16'(diff), 16'h0);
      $display("Done: mode words");
      d1 = 16'($random(seed));
      d2 = 16'($random(seed));
      host.set_pins(1'b1, d1, 1'b0, 1'b0);
      repeat (2) @(negedge lk);
      chk_val(wdata, d1);
      chk_val(16'({t_on, last_be}), 16'h7);
      host.set_pins(1'b0, d2, 1'b0, 1'b1);
      repeat (2) @(negedge lk);
      chk_val(wdata, {d1[15:8], d2[7:0]});
      chk_val(16'({t_on, last_be}), 16'h1);
      host.set_pins(1'b0, ~d2, 1'b1, 1'b0);
      repeat (2) @(negedge lk);
      chk_val(wdata, {~d2[15:8], d2[7:0]});
      chk_val(16'(last_be), 16'h2);
      $display("Done: write data masks");
      stop_test();
   end
endmodule : test_ddrmr_core
